// ---- srb_pkg.sv ----
/*
  Constants for the sensor status, fault and secondary data register group.
  Assumes a byte-wide register port with an 8-bit offset, clocked at 100 MHz.
*/
// Behaviour
// - Offset 0x00 returns fixed part identifier, read-only
// - Fatal flag sets on failure; soft reset clears
// - Persistent code bits 4:2; command failure bit 1
// - Persistent code reads zero without error
// - Code one for invalid accel configuration
// - Buffer drop flag bit 6, cleared on read
// - Secondary-master fault bit 7, cleared on read
// - Fault register resets zero; bit 5 reserved
// - Bit 2 high during manual secondary operation
// - Command idle bit 4 low while executing
// - State flags reset 0x10; reserved bits zero
// - Secondary sample flag bit 5, read clears
// - Accel sample flag bit 7, read clears
// - Secondary words low byte first, reset zero
// - Secondary r high byte at 0x11
package srb_pkg;

  // Register offsets
  localparam logic [7:0] OFF_PART_ID = 8'h00;
  localparam logic [7:0] OFF_FAULT = 8'h02;
  localparam logic [7:0] OFF_STATE = 8'h03;
  localparam logic [7:0] OFF_SEC_X_LO = 8'h0a;
  localparam logic [7:0] OFF_SEC_X_HI = 8'h0b;
  localparam logic [7:0] OFF_SEC_Y_LO = 8'h0c;
  localparam logic [7:0] OFF_SEC_Y_HI = 8'h0d;
  localparam logic [7:0] OFF_SEC_Z_LO = 8'h0e;
  localparam logic [7:0] OFF_SEC_Z_HI = 8'h0f;
  localparam logic [7:0] OFF_SEC_R_LO = 8'h10;
  localparam logic [7:0] OFF_SEC_R_HI = 8'h11;
  localparam logic [7:0] OFF_ACC_FIRST = 8'h12;
  localparam logic [7:0] OFF_ACC_LAST = 8'h17;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h41;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h42;

  // Fault register fields
  localparam int FLT_FATAL = 0;
  localparam int FLT_CMD = 1;
  localparam int FLT_CODE_LO = 2;
  localparam int FLT_CODE_HI = 4;
  localparam int FLT_BUF = 6;
  localparam int FLT_SEC = 7;

  // Persistent fault codes
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_ACCEL_CONFIGURATION_REGISTER = 3'h1;

  // State flags fields
  localparam int ST_MANUAL_OP = 2;
  localparam int ST_CMD_IDLE = 4;
  localparam int ST_SEC_NEW = 5;
  localparam int ST_ACC_NEW = 7;

  // Reset values
  localparam logic [7:0] FAULT_RESET = 8'h00;
  localparam logic [7:0] STATE_RESET = 8'h10;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Interrupt event bit positions
  localparam int EV_FATAL = 0;
  localparam int EV_CMD = 1;
  localparam int EV_BUF = 2;
  localparam int EV_SEC_ERR = 3;
  localparam int EV_SEC_NEW = 4;
  localparam int EV_ACC_NEW = 5;
  localparam int EV_COUNT = 6;

endpackage : srb_pkg

// ---- srb_sticky.sv ----
/*
  Bank of sticky flags: set pulses raise bits, clear pulses drop them.
  Assumes set and clear are synchronous to clk; a set beats a same-cycle clear.
*/
`timescale 1ns/1ns
module srb_sticky #(
  parameter int W = 4
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [W-1:0] set, // Set pulses
  input wire logic [W-1:0] clr, // Clear pulses
  output logic [W-1:0] q // Flag levels
);

  // One flop per flag, set wins over clear
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_flag
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          q[i] <= 1'b0;
        end else if (set[i]) begin
          q[i] <= 1'b1;
        end else if (clr[i]) begin
          q[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : srb_sticky

// ---- srb_regs.sv ----
/*
  Status, fault and secondary sensor data register group with its interrupt.
  Assumes the register port master keeps strobes one cycle long and never both
  at once; event inputs are one-cycle pulses from the rest of the sensor.
*/
`timescale 1ns/1ns
module srb_regs #(
  parameter logic [7:0] PART_ID = 8'h5a // Arbitrary identifier value
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic [7:0] addr, // Register offset
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  output logic irq, // Level interrupt
  input wire logic soft_rst, // Soft reset pulse
  input wire logic fatal_evt, // Boot or power failure pulse
  input wire logic cmd_busy, // Command executing level
  input wire logic cmd_fail, // Command failed pulse
  input wire logic accel_configuration_register_bad, // Accel configuration invalid level
  input wire logic buf_drop, // Stream buffer drop pulse
  input wire logic sec_err_evt, // Secondary master error pulse
  input wire logic manual_secondary_op_flag, // Manual secondary op level
  input wire logic sec_new, // New secondary sample pulse
  input wire logic [15:0] sec_x, // Secondary x word
  input wire logic [15:0] sec_y, // Secondary y word
  input wire logic [15:0] sec_z, // Secondary z word
  input wire logic [15:0] sec_r, // Secondary r word
  input wire logic acc_new, // New accel sample pulse
  input wire logic acc_read // Accel data read elsewhere
);

  // Offset range test used by two decoders
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Access decodes
  logic rd_fault;
  logic rd_sec;
  logic rd_acc;
  logic wr_enable;
  logic wr_clear;

  // Read side effects depend on the offset being read
  assign rd_fault = rd && (addr == srb_pkg::OFF_FAULT);
  assign rd_sec = rd && in_range(addr, srb_pkg::OFF_SEC_X_LO, srb_pkg::OFF_SEC_R_HI);
  assign rd_acc = (rd && in_range(addr, srb_pkg::OFF_ACC_FIRST, srb_pkg::OFF_ACC_LAST)) || acc_read;
  assign wr_enable = wr && (addr == srb_pkg::OFF_IRQ_ENABLE);
  assign wr_clear = wr && (addr == srb_pkg::OFF_IRQ_CLEAR);

  // Fault flag bank: fatal, command, buffer, secondary
  logic [3:0] flt_set;
  logic [3:0] flt_clr;
  logic [3:0] flt_q;

  // Fatal set, cleared by soft reset
  assign flt_set[0] = fatal_evt;
  assign flt_clr[0] = soft_rst;
  assign flt_set[1] = cmd_fail;
  assign flt_clr[1] = rd_fault || soft_rst;
  assign flt_set[2] = buf_drop;
  assign flt_clr[2] = rd_fault || soft_rst;
  assign flt_set[3] = sec_err_evt;
  assign flt_clr[3] = rd_fault || soft_rst;

  srb_sticky #(
    .W(4)
  ) u_fault (
    .clk(clk),
    .nrst(nrst),
    .set(flt_set),
    .clr(flt_clr),
    .q(flt_q)
  );

  // Persistent fault code follows the configuration check
  logic [2:0] code_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      code_r <= srb_pkg::CODE_NONE;
    end else if (accel_configuration_register_bad) begin
      code_r <= srb_pkg::CODE_ACCEL_CONFIGURATION_REGISTER;
    end else begin
      code_r <= srb_pkg::CODE_NONE;
    end
  end

  // Command idle and manual operation levels
  logic cmd_idle_r;
  logic manual_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_idle_r <= srb_pkg::STATE_RESET[srb_pkg::ST_CMD_IDLE];
    end else begin
      cmd_idle_r <= !cmd_busy;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      manual_r <= srb_pkg::STATE_RESET[srb_pkg::ST_MANUAL_OP];
    end else begin
      manual_r <= manual_secondary_op_flag;
    end
  end

  // New-sample flags
  logic sec_new_r;
  logic acc_new_r;

  // Set on sample, cleared by data read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sec_new_r <= srb_pkg::STATE_RESET[srb_pkg::ST_SEC_NEW];
    end else if (sec_new) begin
      sec_new_r <= 1'b1;
    end else if (rd_sec) begin
      sec_new_r <= 1'b0;
    end
  end

  // Set on sample, cleared by data read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_new_r <= srb_pkg::STATE_RESET[srb_pkg::ST_ACC_NEW];
    end else if (acc_new) begin
      acc_new_r <= 1'b1;
    end else if (rd_acc) begin
      acc_new_r <= 1'b0;
    end
  end

  // Secondary sample words held until the next sample
  logic [15:0] sec_x_r;
  logic [15:0] sec_y_r;
  logic [15:0] sec_z_r;
  logic [15:0] sec_r_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sec_x_r <= {srb_pkg::DATA_RESET, srb_pkg::DATA_RESET};
      sec_y_r <= {srb_pkg::DATA_RESET, srb_pkg::DATA_RESET};
      sec_z_r <= {srb_pkg::DATA_RESET, srb_pkg::DATA_RESET};
      sec_r_r <= {srb_pkg::DATA_RESET, srb_pkg::DATA_RESET};
    end else if (sec_new) begin
      sec_x_r <= sec_x;
      sec_y_r <= sec_y;
      sec_z_r <= sec_z;
      sec_r_r <= sec_r;
    end
  end

  // Assembled register images
  logic [7:0] fault_img;
  logic [7:0] state_img;

  // Fault image, bit 5 reserved zero
  always_comb begin
    fault_img = srb_pkg::FAULT_RESET;
    fault_img[srb_pkg::FLT_FATAL] = flt_q[0];
    fault_img[srb_pkg::FLT_CMD] = flt_q[1];
    fault_img[srb_pkg::FLT_CODE_HI:srb_pkg::FLT_CODE_LO] = code_r;
    fault_img[srb_pkg::FLT_BUF] = flt_q[2];
    fault_img[srb_pkg::FLT_SEC] = flt_q[3];
  end

  always_comb begin
    state_img = 8'h00;
    state_img[srb_pkg::ST_MANUAL_OP] = manual_r;
    state_img[srb_pkg::ST_CMD_IDLE] = cmd_idle_r;
    state_img[srb_pkg::ST_SEC_NEW] = sec_new_r;
    state_img[srb_pkg::ST_ACC_NEW] = acc_new_r;
  end

  // Interrupt events, status, enable
  logic [srb_pkg::EV_COUNT-1:0] ev_set;
  logic [srb_pkg::EV_COUNT-1:0] ev_clr;
  logic [srb_pkg::EV_COUNT-1:0] ev_q;
  logic [srb_pkg::EV_COUNT-1:0] ev_en_r;

  // Event pulses into sticky status
  always_comb begin
    ev_set = '0;
    ev_set[srb_pkg::EV_FATAL] = fatal_evt;
    ev_set[srb_pkg::EV_CMD] = cmd_fail;
    ev_set[srb_pkg::EV_BUF] = buf_drop;
    ev_set[srb_pkg::EV_SEC_ERR] = sec_err_evt;
    ev_set[srb_pkg::EV_SEC_NEW] = sec_new;
    ev_set[srb_pkg::EV_ACC_NEW] = acc_new;
  end

  // Writing ones to the clear register drops status bits
  assign ev_clr = wr_clear ? wdata[srb_pkg::EV_COUNT-1:0] : '0;

  srb_sticky #(
    .W(srb_pkg::EV_COUNT)
  ) u_irq_status (
    .clk(clk),
    .nrst(nrst),
    .set(ev_set),
    .clr(ev_clr),
    .q(ev_q)
  );

  // Interrupt enable register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ev_en_r <= '0;
    end else if (wr_enable) begin
      ev_en_r <= wdata[srb_pkg::EV_COUNT-1:0];
    end
  end

  // Interrupt output from a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((ev_q | ev_set) & ~(ev_clr & ~ev_set) & ev_en_r);
    end
  end

  // Read multiplexer
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    case (addr)
      srb_pkg::OFF_PART_ID: rd_mux = PART_ID;
      srb_pkg::OFF_FAULT: rd_mux = fault_img;
      srb_pkg::OFF_STATE: rd_mux = state_img;
      srb_pkg::OFF_SEC_X_LO: rd_mux = sec_x_r[7:0];
      srb_pkg::OFF_SEC_X_HI: rd_mux = sec_x_r[15:8];
      srb_pkg::OFF_SEC_Y_LO: rd_mux = sec_y_r[7:0];
      srb_pkg::OFF_SEC_Y_HI: rd_mux = sec_y_r[15:8];
      srb_pkg::OFF_SEC_Z_LO: rd_mux = sec_z_r[7:0];
      srb_pkg::OFF_SEC_Z_HI: rd_mux = sec_z_r[15:8];
      srb_pkg::OFF_SEC_R_LO: rd_mux = sec_r_r[7:0];
      srb_pkg::OFF_SEC_R_HI: rd_mux = sec_r_r[15:8];
      srb_pkg::OFF_IRQ_STATUS: rd_mux = {{(8 - srb_pkg::EV_COUNT){1'b0}}, ev_q};
      srb_pkg::OFF_IRQ_ENABLE: rd_mux = {{(8 - srb_pkg::EV_COUNT){1'b0}}, ev_en_r};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : srb_regs

// ---- srb_regs_chk.sv ----
/*
  Port checker for the register group.
  Assumes a bind from the bench and a single clock domain.
*/
`timescale 1ns/1ns
module srb_regs_chk #(
  parameter logic [7:0] PART_ID = 8'h5a // Identifier
) (
  input wire logic clk, // Clock
  input wire logic nrst, // Reset
  input wire logic [7:0] addr, // Offset
  input wire logic [7:0] wdata, // Data
  input wire logic wr, // Write
  input wire logic rd, // Read
  input wire logic [7:0] rdata, // Read data
  input wire logic irq, // Interrupt
  input wire logic cmd_busy, // Busy
  input wire logic cmd_fail, // Failed
  input wire logic accel_configuration_register_bad, // Bad config
  input wire logic buf_drop, // Drop
  input wire logic sec_err_evt, // Error
  input wire logic manual_secondary_op_flag, // Manual op
  input wire logic sec_new // New sample
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  id_read_a: assert property ($past(rd && addr == 8'h00) |-> rdata == PART_ID)
    else $error("identifier read wrong");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  cmd_idle_a: assert property ($past(rd && addr == 8'h03) |-> rdata[4] == !$past(cmd_busy, 2))
    else $error("command idle flag wrong");
  manual_op_a: assert property ($past(rd && addr == 8'h03) |->
    rdata[2] == $past(manual_secondary_op_flag, 2) && (rdata & 8'h4b) == 8'h00)
    else $error("manual op flag or reserved bits wrong");
  fault_code_a: assert property ($past(rd && addr == 8'h02) |->
    rdata[5:2] == {3'h0, $past(accel_configuration_register_bad, 2)})
    else $error("persistent fault field wrong");
  unmapped_zero_a: assert property ($past(rd && (addr == 8'h01 || (addr >= 8'h04 && addr <= 8'h09)))
    |-> rdata == 8'h00)
    else $error("unmapped offset not zero");
  read_clear_a: assert property (
    (rd && addr == 8'h02 && !cmd_fail && !buf_drop && !sec_err_evt) ##1 (rd && addr == 8'h02)
    |=> rdata[7:6] == 2'h0 && !rdata[1])
    else $error("fault flags survived a read");
  sec_ready_a: assert property (sec_new ##2 (rd && addr == 8'h03) |=> rdata[5])
    else $error("secondary sample flag missing");
  irq_mask_a: assert property (wr && addr == 8'h41 && wdata == 8'h00 |-> ##2 !irq)
    else $error("interrupt high while masked");
  cover property (sec_new ##2 rd);
  cover property (rd && addr == 8'h02 ##1 rd && addr == 8'h02);
  cover property ($rose(irq));
endmodule : srb_regs_chk

// ---- srb_host.sv ----
/*
  Host model driving the register port.
  Assumes one clock; strobes change after rising edges and last one cycle, except rd in read_pair, which lasts two.
*/
`timescale 1ns/1ns
module srb_host (
  input wire logic clk, // Clock
  output logic [7:0] addr, // Offset
  output logic [7:0] wdata, // Write data
  output logic wr, // Write strobe
  output logic rd, // Read strobe
  input wire logic [7:0] rdata // Read data
);
  // Idle bus at time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One-cycle write
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : write_reg
  // One-cycle read, data taken in the following cycle
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : read_reg
  // Two reads back to back
  task automatic read_pair(input logic [7:0] a, input logic [7:0] b, output logic [7:0] da, output logic [7:0] db);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    addr <= b;
    #1 da = rdata;
    @(posedge clk);
    rd <= 1'b0;
    #1 db = rdata;
  endtask : read_pair
endmodule : srb_host

// ---- srb_regs_bench.sv ----
/*
  Self-checking bench for the register group.
  Assumes the host model and checker files are compiled first.
*/
`timescale 1ns/1ns
module srb_regs_bench;
  localparam logic [7:0] PART_ID = 8'ha7; // Arbitrary identifier value
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, irq;
  logic [7:0] ev = 8'h00; // Event pulses
  logic cmd_busy = 1'b0;
  logic accel_configuration_register_bad = 1'b0;
  logic manual_secondary_op_flag = 1'b0;
  logic [63:0] sec_w = 64'h0; // r, z, y, x words
  int bad_count = 0;
  int tests_run = 0;
  srb_host host (.clk, .addr, .wdata, .wr, .rd, .rdata);
  srb_regs #(.PART_ID(PART_ID)) dut (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .irq,
    .soft_rst(ev[0]), .fatal_evt(ev[1]), .cmd_busy, .cmd_fail(ev[2]), .accel_configuration_register_bad,
    .buf_drop(ev[3]), .sec_err_evt(ev[4]), .manual_secondary_op_flag, .sec_new(ev[5]),
    .sec_x(sec_w[15:0]), .sec_y(sec_w[31:16]), .sec_z(sec_w[47:32]), .sec_r(sec_w[63:48]),
    .acc_new(ev[6]), .acc_read(ev[7]));
  // Clock
  always #5 clk = ~clk;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rcheck(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(a, d);
    check(d, exp);
  endtask : rcheck
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
  endtask : pulse
  task automatic t_reset;
    for (int i = 0; i < 18; i++) begin
      host.write_reg(8'(i), 8'hff);
    end
    for (int i = 0; i < 18; i++) begin
      rcheck(8'(i), i == 0 ? PART_ID : (i == 3 ? 8'h10 : 8'h00));
    end
    $display("reset values done");
  endtask : t_reset
  task automatic t_fault;
    logic [7:0] d0, d1;
    @(posedge clk);
    accel_configuration_register_bad <= 1'b1;
    pulse(8'h1e);
    host.read_pair(8'h02, 8'h02, d0, d1);
    check(d0, 8'hc7);
    check(d1, 8'h05);
    @(posedge clk);
    accel_configuration_register_bad <= 1'b0;
    pulse(8'h01);
    rcheck(8'h02, 8'h00);
    $display("fault flags done");
  endtask : t_fault
  task automatic t_state;
    logic [7:0] d;
    @(posedge clk);
    cmd_busy <= 1'b1;
    manual_secondary_op_flag <= 1'b1;
    rcheck(8'h03, 8'h04);
    @(posedge clk);
    cmd_busy <= 1'b0;
    manual_secondary_op_flag <= 1'b0;
    d = 8'h00;
    for (int n = 0; n < 8 && d[4] !== 1'b1; n++) begin
      host.read_reg(8'h03, d);
    end
    check(d, 8'h10);
    $display("state flags done");
  endtask : t_state
  task automatic t_data;
    @(posedge clk);
    sec_w <= 64'hdef0_9abc_5678_1234;
    pulse(8'h60);
    rcheck(8'h03, 8'hb0);
    for (int i = 0; i < 8; i++) begin
      rcheck(8'(10 + i), sec_w[8 * i +: 8]);
    end
    rcheck(8'h03, 8'h90);
    pulse(8'h80);
    rcheck(8'h03, 8'h10);
    pulse(8'h40);
    rcheck(8'h12, 8'h00);
    rcheck(8'h03, 8'h10);
    $display("secondary data done");
  endtask : t_data
  task automatic t_irq;
    // Drop status left by earlier scenarios
    host.write_reg(8'h42, 8'h3f);
    rcheck(8'h40, 8'h00);
    host.write_reg(8'h41, 8'h3f);
    pulse(8'h02);
    repeat (3) @(posedge clk);
    #1 check({7'h00, irq}, 8'h01);
    host.write_reg(8'h41, 8'h00);
    pulse(8'h04);
    repeat (3) @(posedge clk);
    #1 check({7'h00, irq}, 8'h00);
    rcheck(8'h40, 8'h03);
    host.write_reg(8'h42, 8'h3f);
    rcheck(8'h40, 8'h00);
    rcheck(8'h02, 8'h03);
    $display("interrupt done");
  endtask : t_irq
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_fault();
    t_state();
    t_data();
    t_irq();
    report_and_stop();
  end
  // Watchdog, far beyond the fewer than two hundred cycles needed
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule : srb_regs_bench
bind srb_regs srb_regs_chk #(.PART_ID(PART_ID)) chk (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
  .irq, .cmd_busy, .cmd_fail, .accel_configuration_register_bad, .buf_drop, .sec_err_evt, .manual_secondary_op_flag, .sec_new);
